// *** core/guidance_seq_cfg.svh ***
// Notes on behaviour
// [RL1] steer only in submodes hold, steering, z-axis
// [RL2] submode at entry 400, routine at 410
// [RL3] routine computed every 2 s, any submode
// [RL4] full control: abort armed, auto, backup source
// [RL5] full control: engine-on only in guidance steering
// [RL6] engine-on after N consecutive ullage cycles
// [RL7] ullage when average +X accel above 0.1
// [RL8] cycle without ullage clears the run count
// [RL9] not full control: engine commands mirror engine
// [RL10] cutoff: +X vtg below decay, total below threshold
// [RL11] freeze thrust direction below 15 fps, thrusting
// [RL12] staging starts on request only while engine on
// [RL13] ascent engine confirmed: switch to attitude hold
// [RL14] after programmable delay, enter guidance steering
// [RL15] follow-up: mirror engine, zero attitude error
// [RL16] display errors only under primary auto, both monitors
// [RL17] power selector off: no computing at all
// [RL18] 20 s standby: accept zero, integrate angles
// [RL19] entering operate runs core priming first
// [RL20] operator warms up in standby before operate
// [RL21] operator presses abort or stage abort to arm
// Purpose: constants of the backup guidance sequencer
// Assumes: 25 MHz clock; velocities in 0.1 fps, accels in 0.001 fps^2
// Notes: offsets are operator entry locations
`ifndef GUIDANCE_SEQ_CFG_SVH
`define GUIDANCE_SEQ_CFG_SVH
`define CLOCK_HZ 25000000
`define COMPUTE_PERIOD_S 5'h02
`define STANDBY_READY_S 5'h14
`define PRIME_CYCLES 1024
`define ADDR_SUBMODE 12'h190
`define ADDR_ROUTINE 12'h19A
`define ADDR_ULLAGE_N 12'h1A4
`define ADDR_CUTOFF_THR 12'h1A5
`define ADDR_STAGE_DELAY 12'h1A6
`define ADDR_AVG_ACCEL 12'h1A7
`define SUBMODE_HOLD 17'h00000
`define SUBMODE_STEER 17'h02710
`define SUBMODE_ZAXIS 17'h04E20
`define ULLAGE_N_RST 4'h3
`define CUTOFF_THR_RST 16'h03E8
`define STAGE_DELAY_RST 4'h1
`define STAGE_DELAY_MAX 4'hA
`define ULLAGE_ACCEL 16'h0064
`define FREEZE_VTG 16'h0096
`define PWR_OFF 2'h0
`define PWR_STANDBY 2'h1
`define PWR_OPERATE 2'h2
`endif

// *** core/guidance_seq_pkg.sv ***
// Purpose: types of the backup guidance sequencer
// Assumes: included config supplies the field values
// Notes: none
package guidance_seq_pkg;
   typedef enum logic [1:0] {PS_OFF, PS_STANDBY, PS_PRIMING, PS_OPERATE} power_state_t;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_ASCENT, ST_HOLD_DELAY} stage_state_t;
   typedef struct packed {
      logic [1:0] power_sel;
      logic abort;
      logic abort_stage;
      logic backup_auto;
      logic guid_backup;
      logic primary_auto;
      logic manual_hold;
      logic out_of_detent;
      logic att_mon_backup;
      logic err_mon_cmptr;
      logic engine_running;
      logic ascent_running;
   } switches_t;
   typedef struct packed {
      logic [15:0] accel_x_avg;
      logic [15:0] thrust_accel_x;
      logic [15:0] vtg_x;
      logic [15:0] vtg_total;
      logic [15:0] decay_vel;
   } nav_t;
endpackage : guidance_seq_pkg

// *** core/backup_guidance_engine_sequencer.sv ***
// Purpose: mode and engine-command sequencing of the backup guidance computer
// Assumes: switches are asynchronous pins; nav and entry port share the clock
// Notes: one-second tick divides all timing but priming, which counts 1024 clocks; shorten SECOND_CYCLES in simulation
`include "guidance_seq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module backup_guidance_engine_sequencer
   import guidance_seq_pkg::*;
#(
   parameter int SECOND_CYCLES = `CLOCK_HZ
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // cabin switches and control electronics feedback
   input wire switches_t sw,
   // guidance solution inputs
   input wire nav_t nav,
   // operator entry panel
   input wire logic entry_we,
   input wire logic [11:0] entry_addr,
   input wire logic [16:0] entry_wdata,
   output logic [16:0] entry_rdata,
   // computing status
   output logic compute_tick,
   output logic computing,
   output logic angle_zero_accept,
   output logic euler_integrate,
   output logic [16:0] routine_sel,
   // steering and engine
   output logic full_control,
   output logic steering_enable,
   output logic thrust_dir_freeze,
   output logic engine_on_cmd,
   output logic engine_off_cmd,
   output logic att_error_zero,
   output logic display_err_enable
);
   localparam int PRIME_CYCLES = `PRIME_CYCLES;

   power_state_t power_state;
   stage_state_t stage_state;
   switches_t sw_meta;
   switches_t sw_s;
   logic abort_s_d;
   logic [24:0] sec_cnt;
   logic sec_tick;
   logic [4:0] cyc_sec;
   logic [4:0] standby_secs;
   logic [10:0] prime_cnt;
   logic [16:0] submode;
   logic [3:0] ullage_n;
   logic [15:0] cutoff_thr;
   logic [3:0] stage_delay;
   logic [15:0] avg_accel;
   logic [3:0] ullage_cnt;
   logic [3:0] delay_cnt;
   logic abort_armed;
   logic own_on;
   logic ullage_now;
   logic steer_sel;
   logic followup;
   logic mirror;
   logic stage_req;
   logic cutoff_ok;

   function automatic logic below(input logic [15:0] a, input logic [15:0] b);
      below = a < b;
   endfunction : below

   // two-stage synchroniser for all switch pins
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sw_meta <= '0;
         sw_s <= '0;
      end else begin
         sw_meta <= sw;
         sw_s <= sw_meta;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         abort_s_d <= 1'b0;
      end else begin
         abort_s_d <= sw_s.abort_stage;
      end
   end
   assign stage_req = sw_s.abort_stage && !abort_s_d;

   // power stages
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         power_state <= PS_OFF;
      end else begin
         case (power_state)
            PS_OFF: begin
               if (sw_s.power_sel == `PWR_STANDBY) begin
                  power_state <= PS_STANDBY;
               end
            end
            PS_STANDBY: begin
               if (sw_s.power_sel == `PWR_OFF) begin
                  power_state <= PS_OFF;
               end else if (sw_s.power_sel == `PWR_OPERATE) begin
                  power_state <= PS_PRIMING; // RL19
               end
            end
            PS_PRIMING: begin
               if (sw_s.power_sel == `PWR_OFF) begin
                  power_state <= PS_OFF;
               end else if (prime_cnt == 11'(PRIME_CYCLES - 1)) begin
                  power_state <= PS_OPERATE;
               end
            end
            PS_OPERATE: begin
               if (sw_s.power_sel == `PWR_OFF) begin
                  power_state <= PS_OFF; // RL17
               end else if (sw_s.power_sel == `PWR_STANDBY) begin
                  power_state <= PS_STANDBY;
               end
            end
            default: power_state <= PS_OFF;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prime_cnt <= '0;
      end else if (power_state == PS_PRIMING) begin
         prime_cnt <= prime_cnt + 11'h001;
      end else begin
         prime_cnt <= '0;
      end
   end

   // one-second tick, held still when powered off
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sec_cnt <= '0;
      end else if (power_state == PS_OFF || sec_tick) begin
         sec_cnt <= '0;
      end else begin
         sec_cnt <= sec_cnt + 25'h0000001;
      end
   end
   assign sec_tick = sec_cnt == 25'(SECOND_CYCLES - 1);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         standby_secs <= '0;
      end else if (power_state == PS_OFF) begin
         standby_secs <= '0;
      end else if (sec_tick && standby_secs < `STANDBY_READY_S) begin
         standby_secs <= standby_secs + 5'h01;
      end
   end
   assign angle_zero_accept = power_state != PS_OFF && standby_secs >= `STANDBY_READY_S; // RL18
   assign euler_integrate = angle_zero_accept; // RL18

   // computation cycle, independent of submode
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cyc_sec <= '0;
      end else if (power_state != PS_OPERATE) begin
         cyc_sec <= '0;
      end else if (sec_tick) begin
         cyc_sec <= (cyc_sec == `COMPUTE_PERIOD_S - 5'h01) ? 5'h00 : cyc_sec + 5'h01;
      end
   end
   assign computing = power_state == PS_OPERATE; // RL17
   assign compute_tick = computing && sec_tick && cyc_sec == `COMPUTE_PERIOD_S - 5'h01; // RL3

   // operator entry locations
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         routine_sel <= '0;
         ullage_n <= `ULLAGE_N_RST;
         cutoff_thr <= `CUTOFF_THR_RST;
         stage_delay <= `STAGE_DELAY_RST;
      end else if (entry_we) begin
         case (entry_addr)
            `ADDR_ROUTINE: routine_sel <= entry_wdata; // RL2
            `ADDR_ULLAGE_N: ullage_n <= entry_wdata[3:0]; // RL6
            `ADDR_CUTOFF_THR: cutoff_thr <= entry_wdata[15:0]; // RL10
            `ADDR_STAGE_DELAY: begin
               stage_delay <= (entry_wdata[3:0] > `STAGE_DELAY_MAX) ?
                  `STAGE_DELAY_MAX : entry_wdata[3:0]; // RL14
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         entry_rdata <= '0;
      end else begin
         case (entry_addr)
            `ADDR_SUBMODE: entry_rdata <= submode;
            `ADDR_ROUTINE: entry_rdata <= routine_sel;
            `ADDR_ULLAGE_N: entry_rdata <= {13'h0000, ullage_n};
            `ADDR_CUTOFF_THR: entry_rdata <= {1'b0, cutoff_thr};
            `ADDR_STAGE_DELAY: entry_rdata <= {13'h0000, stage_delay};
            `ADDR_AVG_ACCEL: entry_rdata <= {1'b0, avg_accel}; // RL7
            default: entry_rdata <= '0;
         endcase
      end
   end

   // submode: operator entry, overridden by the staging sequence
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         submode <= `SUBMODE_HOLD;
      end else if (stage_state == ST_WAIT_ASCENT && sw_s.ascent_running) begin
         submode <= `SUBMODE_HOLD; // RL13
      end else if (stage_state == ST_HOLD_DELAY && delay_cnt >= stage_delay) begin
         submode <= `SUBMODE_STEER; // RL14
      end else if (entry_we && entry_addr == `ADDR_SUBMODE) begin
         submode <= entry_wdata; // RL2
      end
   end
   assign steer_sel = submode == `SUBMODE_STEER;

   // control qualification
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         abort_armed <= 1'b0;
      end else if (power_state == PS_OFF) begin
         abort_armed <= 1'b0;
      end else if (sw_s.abort || sw_s.abort_stage) begin
         abort_armed <= 1'b1;
      end
   end
   assign full_control = computing && abort_armed && sw_s.backup_auto && sw_s.guid_backup; // RL4
   assign followup = !sw_s.guid_backup || (sw_s.manual_hold && sw_s.out_of_detent); // RL15
   assign mirror = !full_control || followup; // RL9

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         steering_enable <= 1'b0;
      end else begin
         steering_enable <= computing && !followup && (submode == `SUBMODE_HOLD ||
            steer_sel || submode == `SUBMODE_ZAXIS); // RL1
      end
   end

   // ullage detection over whole computation cycles
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         avg_accel <= '0;
      end else if (compute_tick) begin
         avg_accel <= nav.accel_x_avg; // RL7
      end
   end
   assign ullage_now = nav.accel_x_avg > `ULLAGE_ACCEL; // RL7

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ullage_cnt <= '0;
      end else if (compute_tick) begin
         if (!ullage_now) begin
            ullage_cnt <= '0; // RL8
         end else if (ullage_cnt != 4'hF) begin
            ullage_cnt <= ullage_cnt + 4'h1;
         end
      end
   end

   assign cutoff_ok = below(nav.vtg_x, nav.decay_vel) && below(nav.vtg_total, cutoff_thr);

   // own engine decision
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         own_on <= 1'b0;
      end else if (!full_control || !steer_sel) begin
         own_on <= 1'b0; // RL5
      end else if (own_on && cutoff_ok) begin
         own_on <= 1'b0; // RL10
      end else if (compute_tick && ullage_now && !cutoff_ok &&
         {1'b0, ullage_cnt} + 5'h01 >= {1'b0, ullage_n}) begin
         own_on <= 1'b1; // RL6
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         engine_on_cmd <= 1'b0;
         engine_off_cmd <= 1'b1;
      end else if (mirror) begin
         engine_on_cmd <= sw_s.engine_running; // RL9 RL15
         engine_off_cmd <= !sw_s.engine_running;
      end else begin
         engine_on_cmd <= own_on && steer_sel; // RL5
         engine_off_cmd <= !(own_on && steer_sel);
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         thrust_dir_freeze <= 1'b0;
      end else begin
         thrust_dir_freeze <= full_control && below(nav.vtg_total, `FREEZE_VTG) &&
            nav.thrust_accel_x > `ULLAGE_ACCEL; // RL11
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         att_error_zero <= 1'b1;
         display_err_enable <= 1'b0;
      end else begin
         att_error_zero <= followup || !computing; // RL15
         display_err_enable <= computing && !sw_s.guid_backup && sw_s.primary_auto &&
            sw_s.att_mon_backup && sw_s.err_mon_cmptr; // RL16
      end
   end

   // staging sequence
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stage_state <= ST_IDLE;
      end else if (!computing) begin
         stage_state <= ST_IDLE;
      end else begin
         case (stage_state)
            ST_IDLE: begin
               if (stage_req && engine_on_cmd) begin
                  stage_state <= ST_WAIT_ASCENT; // RL12
               end
            end
            ST_WAIT_ASCENT: begin
               if (sw_s.ascent_running) begin
                  stage_state <= ST_HOLD_DELAY; // RL13
               end
            end
            ST_HOLD_DELAY: begin
               if (delay_cnt >= stage_delay) begin
                  stage_state <= ST_IDLE; // RL14
               end
            end
            default: stage_state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         delay_cnt <= '0;
      end else if (stage_state != ST_HOLD_DELAY) begin
         delay_cnt <= '0;
      end else if (sec_tick && delay_cnt != 4'hF) begin
         delay_cnt <= delay_cnt + 4'h1;
      end
   end

   // checks
   sequence s_ascent_seen;
      stage_state == ST_WAIT_ASCENT && sw_s.ascent_running;
   endsequence
   sequence s_hold_entered;
      submode == `SUBMODE_HOLD && stage_state == ST_HOLD_DELAY;
   endsequence

   property p_off_idle;
      @(posedge clock) disable iff (!arst_n)
      power_state == PS_OFF |-> !compute_tick && !full_control ##1 !steering_enable;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("computing while off"); // RL17

   property p_stage_hold;
      @(posedge clock) disable iff (!arst_n)
      s_ascent_seen |=> s_hold_entered;
   endproperty
   a_stage_hold: assert property (p_stage_hold) else $error("no hold after ascent"); // RL13

   property p_mirror;
      @(posedge clock) disable iff (!arst_n)
      !full_control |=> engine_on_cmd == $past(sw_s.engine_running);
   endproperty
   a_mirror: assert property (p_mirror) else $error("engine not mirrored"); // RL9

   property p_on_needs_steer;
      @(posedge clock) disable iff (!arst_n)
      full_control && !followup && !steer_sel |=> !engine_on_cmd;
   endproperty
   a_on_needs_steer: assert property (p_on_needs_steer) else $error("on outside steering"); // RL5

   property p_ullage_clear;
      @(posedge clock) disable iff (!arst_n)
      compute_tick && !ullage_now |=> ullage_cnt == 4'h0;
   endproperty
   a_ullage_clear: assert property (p_ullage_clear) else $error("run count kept"); // RL8

   property p_engine_on;
      @(posedge clock) disable iff (!arst_n)
      compute_tick && ullage_now && ullage_cnt == 4'h2 && ullage_n == 4'h3 && full_control &&
         steer_sel && !own_on && !cutoff_ok ##1 full_control && steer_sel |-> own_on;
   endproperty
   a_engine_on: assert property (p_engine_on) else $error("no engine on after ullage"); // RL6

   property p_freeze;
      @(posedge clock) disable iff (!arst_n)
      full_control && nav.vtg_total < `FREEZE_VTG && nav.thrust_accel_x > `ULLAGE_ACCEL
         |=> thrust_dir_freeze;
   endproperty
   a_freeze: assert property (p_freeze) else $error("direction not frozen"); // RL11

   property p_zero_accept;
      @(posedge clock) disable iff (!arst_n)
      angle_zero_accept |-> standby_secs == `STANDBY_READY_S;
   endproperty
   a_zero_accept: assert property (p_zero_accept) else $error("zero accepted early"); // RL18

   property p_priming;
      @(posedge clock) disable iff (!arst_n)
      power_state == PS_OPERATE && $past(power_state) != PS_OPERATE |->
         $past(power_state) == PS_PRIMING;
   endproperty
   a_priming: assert property (p_priming) else $error("operate without priming"); // RL19

   property p_followup;
      @(posedge clock) disable iff (!arst_n)
      followup |=> att_error_zero;
   endproperty
   a_followup: assert property (p_followup) else $error("error not zero in follow-up"); // RL15
endmodule : backup_guidance_engine_sequencer
`default_nettype wire

// *** bench/control_electronics_model.sv ***
// Purpose: control electronics and engine model facing the sequencer
// Assumes: one clock; slow stretches the ascent engine confirmation
// Notes: engine obeys the sequencer only under full control
`timescale 1ns/1ps
`default_nettype none
module control_electronics_model (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // commands
   input wire logic full_ctl,
   input wire logic engine_on_cmd,
   input wire logic manual_engine,
   input wire logic abort_stage,
   input wire logic slow,
   // feedback
   output logic engine_running,
   output logic ascent_running
);
   logic [5:0] stage_cnt;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         engine_running <= 1'b0;
      end else begin
         engine_running <= full_ctl ? engine_on_cmd : manual_engine;
      end
   end
   // stage button arms the ascent engine, confirmed after a delay
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stage_cnt <= 6'h00;
      end else if (!abort_stage) begin
         stage_cnt <= 6'h00;
      end else if (stage_cnt != 6'h3F) begin
         stage_cnt <= stage_cnt + 6'h01;
      end
   end
   assign ascent_running = stage_cnt > (slow ? 6'h1E : 6'h03);
endmodule : control_electronics_model
`default_nettype wire

// *** bench/backup_guidance_engine_sequencer_test.sv ***
// Purpose: self-checking bench of the backup guidance sequencer
// Assumes: one second shortened to 20 clocks
// Notes: inputs change at the falling edge
`include "guidance_seq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module backup_guidance_engine_sequencer_test import guidance_seq_pkg::*;;
   localparam int SEC = 20;
   logic clock, arst_n, entry_we, manual_engine, slow;
   switches_t pan, sw;
   nav_t nav;
   logic [11:0] entry_addr;
   logic [16:0] entry_wdata, entry_rdata, routine_sel, v;
   logic compute_tick, computing, angle_zero_accept, euler_integrate, full_control;
   logic steering_enable, thrust_dir_freeze, engine_on_cmd, engine_off_cmd;
   logic att_error_zero, display_err_enable, engine_running, ascent_running;
   logic [16:0] codes [4] = '{`SUBMODE_HOLD, `SUBMODE_ZAXIS, 17'h04E21, `SUBMODE_STEER};
   logic [15:0] fz [3][2] = '{'{16'h0095, 16'h0065}, '{16'h0096, 16'h0065},
      '{16'h0095, 16'h0064}};
   int failures, samples_checked, cycles, n;
   logic [31:0] seed;
   always_comb begin
      sw = pan;
      sw.engine_running = engine_running;
      sw.ascent_running = ascent_running;
   end
   backup_guidance_engine_sequencer #(.SECOND_CYCLES(SEC)) dut (.clock(clock), .arst_n(arst_n),
      .sw(sw), .nav(nav), .entry_we(entry_we), .entry_addr(entry_addr),
      .entry_wdata(entry_wdata), .entry_rdata(entry_rdata), .compute_tick(compute_tick),
      .computing(computing), .angle_zero_accept(angle_zero_accept),
      .euler_integrate(euler_integrate), .routine_sel(routine_sel),
      .full_control(full_control), .steering_enable(steering_enable),
      .thrust_dir_freeze(thrust_dir_freeze), .engine_on_cmd(engine_on_cmd),
      .engine_off_cmd(engine_off_cmd), .att_error_zero(att_error_zero),
      .display_err_enable(display_err_enable));
   control_electronics_model control_electronics (.clock(clock), .arst_n(arst_n), .full_ctl(full_control),
      .engine_on_cmd(engine_on_cmd), .manual_engine(manual_engine),
      .abort_stage(pan.abort_stage), .slow(slow), .engine_running(engine_running),
      .ascent_running(ascent_running));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic exp_disp(input logic [2:0] s, input logic gb);
      return &s & !gb;
   endfunction : exp_disp
   function automatic logic exp_steer(input logic [16:0] c);
      return c == `SUBMODE_HOLD || c == `SUBMODE_STEER || c == `SUBMODE_ZAXIS;
   endfunction : exp_steer
   task automatic close_out;
      if (failures == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out
   task automatic cyc(input int k);
      repeat (k) @(negedge clock);
   endtask : cyc
   task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [16:0] d);
      entry_addr = a;
      entry_wdata = d;
      entry_we = 1'b1;
      cyc(1);
      entry_we = 1'b0;
      cyc(1);
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [16:0] d);
      entry_addr = a;
      cyc(2);
      d = entry_rdata;
   endtask : rd
   // returns three cycles past the tick edge
   task automatic wait_tick(input int k);
      repeat (k) begin
         n = 0;
         do begin
            cyc(1);
            n++;
         end while (compute_tick !== 1'b1 && n < 200);
         if (n >= 200) begin
            failures++;
            close_out();
         end
         cyc(3);
      end
   endtask : wait_tick
   task automatic wait_sub(input logic [16:0] code, input int lim);
      n = 0;
      entry_addr = `ADDR_SUBMODE;
      do begin
         cyc(1);
         n++;
      end while (entry_rdata !== code && n < lim);
      check("submode", code, entry_rdata);
   endtask : wait_sub
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 10000) begin
         failures++;
         close_out();
      end
   end
   initial begin
      seed = 32'h4678;
      failures = 0;
      samples_checked = 0;
      cycles = 0;
      arst_n = 1'b0;
      pan = '0;
      nav = '0;
      entry_we = 1'b0;
      entry_addr = 12'h000;
      entry_wdata = 17'h00000;
      manual_engine = 1'b0;
      slow = 1'b0;
      cyc(11);
      check("off_cmd", 1, engine_off_cmd);
      check("err_zero", 1, att_error_zero);
      cyc(1);
      arst_n = 1'b1;
      rd(`ADDR_ULLAGE_N, v);
      check("ullage_n", 17'h00003, v);
      rd(`ADDR_CUTOFF_THR, v);
      check("cutoff_thr", 17'h003E8, v);
      rd(`ADDR_STAGE_DELAY, v);
      check("stage_delay", 17'h00001, v);
      seed = lfsr(seed);
      wr(`ADDR_ROUTINE, seed[16:0]);
      rd(`ADDR_ROUTINE, v);
      check("routine", seed[16:0], v);
      check("routine_sel", seed[16:0], routine_sel);
      wr(`ADDR_STAGE_DELAY, 17'h0000F);
      rd(`ADDR_STAGE_DELAY, v);
      check("delay_clamp", 17'h0000A, v);
      wr(12'hC00 | seed[25:16], seed[16:0]);
      rd(12'hC00 | seed[25:16], v);
      check("unmapped", 17'h00000, v);
      nav.accel_x_avg = seed[31:16];
      rd(`ADDR_AVG_ACCEL, v);
      check("avg_accel", 17'h00000, v);
      nav = '{16'h0000, 16'h0000, 16'hFFFF, 16'hF000, 16'h0010};
      pan.power_sel = `PWR_OPERATE;
      cyc(10);
      check("computing", 0, computing);
      pan.power_sel = `PWR_STANDBY;
      cyc(18 * SEC);
      check("zero_accept", 0, angle_zero_accept);
      cyc(4 * SEC);
      check("zero_accept", 1, angle_zero_accept);
      check("integrate", 1, euler_integrate);
      pan.power_sel = `PWR_OPERATE;
      cyc(1000);
      check("computing", 0, computing);
      cyc(40);
      check("computing", 1, computing);
      wr(`ADDR_SUBMODE, 17'h00005);
      wait_tick(2);
      check("tick_gap", 2 * SEC - 3, n[16:0]);
      check("steer_en", 0, steering_enable);
      for (int i = 0; i < 8; i++) begin
         pan.abort = i[2];
         pan.backup_auto = i[1];
         pan.guid_backup = i[0];
         cyc(4);
         check("full_control", i == 7, full_control);
      end
      for (int i = 0; i < 4; i++) begin
         pan.guid_backup = i[1];
         pan.backup_auto = !i[1];
         manual_engine = i[0];
         cyc(6);
         check("on_cmd", i[0], engine_on_cmd);
         check("off_cmd", !i[0], engine_off_cmd);
         if (i < 2) check("err_zero", 1, att_error_zero);
      end
      manual_engine = 1'b0;
      pan.guid_backup = 1'b0;
      for (int i = 0; i < 9; i++) begin
         {pan.guid_backup, pan.primary_auto, pan.att_mon_backup, pan.err_mon_cmptr} = i[3:0];
         if (i == 8) pan.guid_backup = 1'b1;
         cyc(5);
         check("disp_en", exp_disp(i[2:0], i[3]), display_err_enable);
      end
      pan.backup_auto = 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(`ADDR_SUBMODE, codes[i]);
         cyc(3);
         check("steer_en", exp_steer(codes[i]), steering_enable);
      end
      for (int i = 3; i >= 0; i--) begin
         {pan.manual_hold, pan.out_of_detent} = i[1:0];
         cyc(5);
         check("err_zero", i == 3, att_error_zero);
      end
      nav.accel_x_avg = 16'h0064;
      pan.abort_stage = 1'b1;
      wait_tick(3);
      check("on_cmd", 0, engine_on_cmd);
      check("submode", `SUBMODE_STEER, entry_rdata);
      pan.abort_stage = 1'b0;
      nav.accel_x_avg = 16'h0065;
      wait_tick(2);
      rd(`ADDR_AVG_ACCEL, v);
      check("avg_accel", 17'h00065, v);
      nav.accel_x_avg = 16'h0000;
      wait_tick(1);
      nav.accel_x_avg = 16'h0065;
      wait_tick(2);
      check("on_cmd", 0, engine_on_cmd);
      wait_tick(1);
      check("on_cmd", 1, engine_on_cmd);
      check("off_cmd", 0, engine_off_cmd);
      for (int i = 0; i < 3; i++) begin
         nav.vtg_total = fz[i][0];
         nav.thrust_accel_x = fz[i][1];
         wait_tick(1);
         check("freeze", i == 0, thrust_dir_freeze);
      end
      nav.vtg_total = 16'hF000;
      wr(`ADDR_STAGE_DELAY, 17'h00002);
      slow = 1'b1;
      pan.abort_stage = 1'b1;
      wait_sub(`SUBMODE_HOLD, 60);
      check("ascent_wait", 1, n > 30);
      cyc(18);
      check("submode", `SUBMODE_HOLD, entry_rdata);
      wait_sub(`SUBMODE_STEER, 30);
      pan.abort_stage = 1'b0;
      wait_tick(1);
      check("on_cmd", 1, engine_on_cmd);
      seed = lfsr(seed);
      nav.decay_vel = seed[15:0] | 16'h0100;
      wr(`ADDR_CUTOFF_THR, 17'h00400);
      for (int i = 0; i < 3; i++) begin
         nav.vtg_x = nav.decay_vel - (i != 1);
         nav.vtg_total = 16'h0400 - (i != 0);
         cyc(5);
         check("on_cmd", i < 2, engine_on_cmd);
      end
      check("off_cmd", 1, engine_off_cmd);
      nav.vtg_x = 16'hFFFF;
      nav.vtg_total = 16'hF000;
      wr(`ADDR_SUBMODE, `SUBMODE_HOLD);
      wait_tick(4);
      check("on_cmd", 0, engine_on_cmd);
      pan.power_sel = `PWR_OFF;
      cyc(5);
      check("computing", 0, computing);
      check("zero_accept", 0, angle_zero_accept);
      n = 0;
      repeat (100) begin
         cyc(1);
         if (compute_tick === 1'b1) n++;
      end
      check("ticks_off", 0, n[16:0]);
      close_out();
   end
endmodule : backup_guidance_engine_sequencer_test
`default_nettype wire
